// *** scc_pkg.sv ***
// Notes on behaviour
// RULE_01 - Branch metric: one cycle, two at rate 1/3
// RULE_02 - Add-compare-select butterfly takes two cycles
// RULE_03 - Traceback takes three cycles per stage
// RULE_04 - FFT butterfly stage takes five cycles
// RULE_05 - Complex multiply, four products, one cycle
// RULE_06 - Complex load or store in one cycle
// RULE_07 - CRC widths 8-32, runs without stalling host
// RULE_08 - CRC consumes one byte every cycle
// RULE_09 - CRC result register updates per CRC instruction
// RULE_10 - Nine result, two traceback, config, CRC registers
// RULE_11 - Operations issue as ordinary host instructions
// RULE_12 - Config selects rate and width; CRC kept
package scc_pkg;
  localparam int NUM_RESULT = 9;
  localparam int NUM_TB = 2;
  localparam int CNT_W = 3;
  localparam int Q_FRAC = 15;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [CNT_W-1:0] CYC_BMET_R2 = 3'h1;
  localparam logic [CNT_W-1:0] CYC_BMET_R3 = 3'h2;
  localparam logic [CNT_W-1:0] CYC_ACS = 3'h2;
  localparam logic [CNT_W-1:0] CYC_TRACE = 3'h3;
  localparam logic [CNT_W-1:0] CYC_FFT = 3'h5;
  localparam logic [CNT_W-1:0] CYC_CMPY = 3'h1;
  localparam logic [CNT_W-1:0] CYC_MEM = 3'h1;
  // Read indices above the result file.
  localparam logic [3:0] IDX_TB0 = 4'h9;
  localparam logic [3:0] IDX_TB1 = 4'hA;
  localparam logic [3:0] IDX_CFG = 4'hB;
  localparam logic [3:0] IDX_CRC = 4'hC;
  // Configuration-and-status fields.
  localparam int CFG_RATE_BIT = 0;
  localparam int CFG_CRCW_LSB = 1;
  localparam int CFG_BUSY_BIT = 3;
  localparam logic [31:0] CFG_WR_MASK = 32'h0000_0007;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CRC_RESET = 32'h0000_0000;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_BMET = 4'h1, OP_ACS = 4'h2, OP_TRACE = 4'h3, OP_FFT = 4'h4,
    OP_CMPY = 4'h5, OP_CLD = 4'h6, OP_CST = 4'h7, OP_CRC = 4'h8, OP_CFG = 4'h9
  } scc_op_type;

  // Q15 complex product of packed {re, im} words with four real multiplies.
  function automatic logic [31:0] scc_cmul(input logic [31:0] a, input logic [31:0] b);
    logic signed [15:0] ar, ai, br, bi;
    logic signed [32:0] re, im;
    ar = a[31:16];
    ai = a[15:0];
    br = b[31:16];
    bi = b[15:0];
    // Widen each operand first, so that no product is cut before the sum.
    re = 33'(ar) * 33'(br) - 33'(ai) * 33'(bi);
    im = 33'(ar) * 33'(bi) + 33'(ai) * 33'(br);
    return {re[Q_FRAC +: HALF_W], im[Q_FRAC +: HALF_W]};
  endfunction

  // One byte into the CRC; width code 0..3 means 8..32 bits, kept MSB aligned inside.
  function automatic logic [31:0] scc_crc_byte(input logic [31:0] c, input logic [7:0] b,
                                               input logic [31:0] poly, input logic [1:0] w);
    logic [31:0] x, p;
    logic [5:0] sh;
    sh = {1'b0, ~w, 3'h0};
    x = (c << sh) ^ {b, 24'h00_0000};
    p = poly << sh;
    for (int i = 0; i < BYTE_W; i++)
    begin
      x = x[31] ? ((x << 1) ^ p) : (x << 1);
    end
    return x >> sh;
  endfunction
endpackage

// *** scc_signal_comm_coprocessor.sv ***
`timescale 1ns/10ps
module scc_signal_comm_coprocessor (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               opValid,
  input  wire scc_pkg::scc_op_type opCode,
  input  wire logic [31:0]        opA,
  input  wire logic [31:0]        opB,
  input  wire logic [31:0]        opC,
  output logic                    opReady,
  output logic                    opDone,
  output logic                    busy,
  input  wire logic [31:0]        memRdData,
  output logic [31:0]             memWrData,
  output logic                    memWrEn,
  input  wire logic [3:0]         rdIdx,
  output logic [31:0]             rdData
);
  import scc_pkg::*;

  typedef enum logic {ST_IDLE, ST_EXEC} scc_state_type;

  scc_state_type    state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  scc_op_type       op, next_op;
  logic [31:0]      a, next_a, b, next_b, c, next_c, mem, next_mem;
  logic             rate, next_rate;
  logic [31:0]      res [NUM_RESULT];
  logic [31:0]      next_res [NUM_RESULT];
  logic [31:0]      tb [NUM_TB];
  logic [31:0]      next_tb [NUM_TB];
  logic [31:0]      cfg, next_cfg, crc, next_crc;
  logic [31:0]      next_memWrData, next_rdData;
  logic             next_memWrEn;
  logic             accept, acceptCrc, acceptCfg, acceptExec;
  logic [CNT_W-1:0] cycles;

  // CRC never waits for the datapath, so it is taken even while busy.
  always_comb
  begin
    busy = (state == ST_EXEC);
    opReady = !busy || (opCode == OP_CRC); // RULE_07
    opDone = busy && (cnt == '0);
    accept = opValid && opReady; // RULE_11
    acceptCrc = accept && (opCode == OP_CRC);
    acceptCfg = accept && (opCode == OP_CFG);
    acceptExec = accept && !acceptCrc && !acceptCfg && (opCode != OP_NOP);
  end

  // Cycle budget per operation; rate comes from the live configuration.
  always_comb
  begin
    case (opCode)
      OP_BMET:  cycles = cfg[CFG_RATE_BIT] ? CYC_BMET_R3 : CYC_BMET_R2; // RULE_01 RULE_12
      OP_ACS:   cycles = CYC_ACS; // RULE_02
      OP_TRACE: cycles = CYC_TRACE; // RULE_03
      OP_FFT:   cycles = CYC_FFT; // RULE_04
      OP_CMPY:  cycles = CYC_CMPY; // RULE_05
      default:  cycles = CYC_MEM; // RULE_06
    endcase
  end

  // Datapath next values; results land on the cycle after the done strobe shows.
  always_comb
  begin
    logic signed [15:0] m0, m1, bm, c00, c01, c10, c11, n0, n1, s0, s1, s2;
    logic [31:0] t;
    logic d0, d1, bit0;
    next_state = state;
    next_cnt = cnt;
    next_op = op;
    next_a = a;
    next_b = b;
    next_c = c;
    next_mem = mem;
    next_rate = rate;
    next_res = res;
    next_tb = tb;
    next_cfg = cfg;
    next_crc = crc;
    next_memWrData = memWrData;
    next_memWrEn = 1'b0;
    s0 = a[15:0];
    s1 = a[31:16];
    s2 = b[15:0];
    m0 = a[15:0];
    m1 = a[31:16];
    bm = b[15:0];
    c00 = m0 + bm;
    c01 = m1 - bm;
    c10 = m0 - bm;
    c11 = m1 + bm;
    d0 = (c01 < c00);
    d1 = (c11 < c10);
    n0 = d0 ? c01 : c00;
    n1 = d1 ? c11 : c10;
    t = scc_cmul(b, c);
    bit0 = tb[0][a[4:0]];
    if (acceptExec)
    begin
      next_state = ST_EXEC;
      next_cnt = cycles - 3'h1;
      next_op = opCode;
      next_a = opA;
      next_b = opB;
      next_c = opC;
      next_mem = memRdData;
      next_rate = cfg[CFG_RATE_BIT];
    end
    else if (opDone)
    begin
      next_state = ST_IDLE;
      case (op)
        OP_BMET:
        begin
          next_res[0] = {16'(s0 + s1), 16'(s0 - s1)};
          next_res[1] = rate ? {16'(s0 + s1 + s2), 16'(s0 + s1 - s2)} : 32'h0000_0000;
        end
        OP_ACS:
        begin
          next_res[2] = {n1, n0};
          next_res[3] = {30'h0000_0000, d1, d0};
          next_tb[0] = {tb[0][29:0], d1, d0};
        end
        OP_TRACE:
        begin
          next_res[4] = {27'h000_0000, a[3:0], bit0};
          next_tb[1] = {tb[1][30:0], bit0};
        end
        OP_FFT:
        begin
          next_res[5] = {16'(a[31:16] + t[31:16]), 16'(a[15:0] + t[15:0])};
          next_res[6] = {16'(a[31:16] - t[31:16]), 16'(a[15:0] - t[15:0])};
        end
        OP_CMPY: next_res[7] = scc_cmul(a, b);
        OP_CLD:  next_res[8] = mem;
        OP_CST:
        begin
          next_memWrData = res[8];
          next_memWrEn = 1'b1;
        end
        default: next_res = res;
      endcase
    end
    else if (busy)
    begin
      next_cnt = cnt - 3'h1;
    end
    if (acceptCfg)
    begin
      next_cfg = opA & CFG_WR_MASK; // RULE_12
    end
    if (acceptCrc)
    begin
      next_crc = scc_crc_byte(crc, opA[7:0], opB, cfg[CFG_CRCW_LSB +: 2]); // RULE_08 RULE_09
    end
  end

  // Registered read port; status shows the busy state live.
  always_comb
  begin
    if (rdIdx < 4'(NUM_RESULT))
      next_rdData = res[rdIdx]; // RULE_10
    else if (rdIdx == IDX_TB0)
      next_rdData = tb[0];
    else if (rdIdx == IDX_TB1)
      next_rdData = tb[1];
    else if (rdIdx == IDX_CFG)
      next_rdData = cfg | (32'(busy) << CFG_BUSY_BIT);
    else if (rdIdx == IDX_CRC)
      next_rdData = crc;
    else
      next_rdData = 32'h0000_0000;
  end

  // All state registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      op <= OP_NOP;
      a <= '0;
      b <= '0;
      c <= '0;
      mem <= '0;
      rate <= 1'b0;
      for (int i = 0; i < NUM_RESULT; i++)
        res[i] <= '0;
      for (int i = 0; i < NUM_TB; i++)
        tb[i] <= '0;
      cfg <= CFG_RESET;
      crc <= CRC_RESET;
      memWrData <= '0;
      memWrEn <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      a <= next_a;
      b <= next_b;
      c <= next_c;
      mem <= next_mem;
      rate <= next_rate;
      res <= next_res;
      tb <= next_tb;
      cfg <= next_cfg;
      crc <= next_crc;
      memWrData <= next_memWrData;
      memWrEn <= next_memWrEn;
      rdData <= next_rdData;
    end
  end

  // Latency checks; the done strobe must arrive exactly on budget.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_done1; opDone; endsequence
  sequence s_done2; !opDone ##1 opDone; endsequence
  property p_bmet_r2;
    acceptExec && opCode == OP_BMET && !cfg[CFG_RATE_BIT] |=> s_done1;
  endproperty
  a_bmet_r2: assert property (p_bmet_r2) else $error("rate 1/2 metric late"); // RULE_01
  property p_bmet_r3;
    acceptExec && opCode == OP_BMET && cfg[CFG_RATE_BIT] |=> s_done2;
  endproperty
  a_bmet_r3: assert property (p_bmet_r3) else $error("rate 1/3 metric late"); // RULE_01
  property p_acs;
    acceptExec && opCode == OP_ACS |=> s_done2 ##1 res[3][1:0] == tb[0][1:0];
  endproperty
  a_acs: assert property (p_acs) else $error("butterfly timing wrong"); // RULE_02
  property p_trace;
    acceptExec && opCode == OP_TRACE |=> (!opDone)[*2] ##1 opDone;
  endproperty
  a_trace: assert property (p_trace) else $error("traceback timing wrong"); // RULE_03
  property p_fft;
    acceptExec && opCode == OP_FFT |=> (busy && !opDone)[*4] ##1 opDone ##1 !busy;
  endproperty
  a_fft: assert property (p_fft) else $error("fft stage timing wrong"); // RULE_04
  property p_cmpy;
    acceptExec && opCode == OP_CMPY |=> opDone ##1 res[7] == scc_cmul($past(opA, 2), $past(opB, 2));
  endproperty
  a_cmpy: assert property (p_cmpy) else $error("complex product wrong"); // RULE_05
  property p_cld;
    acceptExec && opCode == OP_CLD |=> opDone ##1 res[8] == $past(memRdData, 2);
  endproperty
  a_cld: assert property (p_cld) else $error("complex load wrong"); // RULE_06
  // A byte offered while the datapath is busy must still land on the next edge.
  property p_crc_bg;
    opValid && opCode == OP_CRC && busy |=> crc == scc_crc_byte($past(crc), $past(opA[7:0]),
                                            $past(opB), $past(cfg[CFG_CRCW_LSB +: 2]));
  endproperty
  a_crc_bg: assert property (p_crc_bg) else $error("crc stalled"); // RULE_07
  property p_crc_upd;
    acceptCrc |=> crc == scc_crc_byte($past(crc), $past(opA[7:0]), $past(opB),
                                      $past(cfg[CFG_CRCW_LSB +: 2]));
  endproperty
  a_crc_upd: assert property (p_crc_upd) else $error("crc not updated"); // RULE_08
  property p_crc_hold;
    !acceptCrc |=> $stable(crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc changed"); // RULE_12
endmodule

// *** scc_host_model.sv ***
`timescale 1ns/10ps
// Host pipeline stand-in: issues one instruction and holds it until accepted.
module scc_host_model (
  input  wire logic                clk,
  input  wire logic                opReady,
  output logic                     opValid,
  output scc_pkg::scc_op_type      opCode,
  output logic [31:0]              opA,
  output logic [31:0]              opB,
  output logic [31:0]              opC
);
  import scc_pkg::*;
  // Idle at time zero so nothing is issued during reset.
  initial
  begin
    opValid = 1'b0;
    opCode = OP_NOP;
    opA = 32'h0;
    opB = 32'h0;
    opC = 32'h0;
  end
  // Call just after a rising edge; returns at the edge that takes the request.
  task automatic issue(input scc_op_type c, input logic [31:0] a, b, d);
    opValid <= 1'b1;
    opCode <= c;
    opA <= a;
    opB <= b;
    opC <= d;
    do @(posedge clk); while (opReady !== 1'b1);
  endtask
  // Operands are scrambled once released so stale values cannot pass.
  task automatic idle();
    opValid <= 1'b0;
    opA <= ~opA;
    opB <= ~opB;
    opC <= ~opC;
  endtask
endmodule

// *** tb_viterbi_complex_crc_coprocessor.sv ***
`timescale 1ns/10ps
module tb_viterbi_complex_crc_coprocessor;
  import scc_pkg::*;
  logic clk, resetn, opValid, opReady, opDone, busy, memWrEn;
  scc_op_type opCode;
  logic [31:0] opA, opB, opC, memRdData, memWrData, rdData, n, v, ex;
  logic [3:0] rdIdx;
  int cyc, t0, miscompares, samples_checked;
  scc_host_model host (.clk(clk), .opReady(opReady), .opValid(opValid), .opCode(opCode),
    .opA(opA), .opB(opB), .opC(opC));
  scc_signal_comm_coprocessor dut (.clk(clk), .resetn(resetn), .opValid(opValid),
    .opCode(opCode), .opA(opA), .opB(opB), .opC(opC), .opReady(opReady), .opDone(opDone),
    .busy(busy), .memRdData(memRdData), .memWrData(memWrData), .memWrEn(memWrEn),
    .rdIdx(rdIdx), .rdData(rdData));
  // Cycle count on the falling edge so it never races the request edge.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) cyc++;
  task automatic check(input string s, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Issue one timed operation and count cycles up to its completion pulse.
  task automatic run(input scc_op_type c, input logic [31:0] a, b, d);
    @(posedge clk);
    host.issue(c, a, b, d);
    host.idle();
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (opDone !== 1'b1 && n < 20);
  endtask
  task automatic cfg(input logic [31:0] x);
    @(posedge clk);
    host.issue(OP_CFG, x, 32'h0, 32'h0);
    host.idle();
  endtask
  task automatic rd(input logic [3:0] i);
    @(posedge clk);
    rdIdx <= i;
    @(posedge clk);
    @(negedge clk);
    v = rdData;
  endtask
  // Independent MSB-first reference; the mask keeps only the active width.
  function automatic logic [31:0] crcRef(input logic [31:0] c, input logic [7:0] b, int w);
    logic [31:0] m;
    m = (32'h1 << w) - 32'h1;
    c = c ^ (b << (w - 8));
    for (int i = 0; i < 8; i++)
      c = c[w-1] ? ((c << 1) ^ 32'h04C1_1DB7) & m : (c << 1) & m;
    return c;
  endfunction
  task automatic t_viterbi();
    @(posedge clk);
    host.issue(OP_NOP, 32'h0, 32'h0, 32'h0);
    host.idle();
    @(negedge clk);
    check("nop", busy, 0);
    check("nopdone", opDone, 0);
    rd(IDX_CFG); check("cfg", v, 32'h0);
    rd(IDX_CRC); check("crc", v, 32'h0);
    rd(4'hD); check("spare", v, 32'h0);
    run(OP_BMET, 32'h0001_0003, 32'h0, 32'h0); check("bm1", n, 1);
    rd(4'h0); check("res0", v, 32'h0004_0002);
    cfg(32'h1);
    run(OP_BMET, 32'h0001_0003, 32'h1, 32'h0); check("bm2", n, 2);
    rd(4'h1); check("res1", v, 32'h0005_0003);
    run(OP_ACS, 32'h0002_0001, 32'h1, 32'h0); check("acs", n, 2);
    rd(4'h2);
    check("res2", v, 32'h0000_0001);
    rd(IDX_TB0);
    check("tb0", v, 32'h0000_0001);
    run(OP_TRACE, 32'h0, 32'h0, 32'h0); check("trace", n, 3);
    rd(4'h4);
    check("res4", v, 32'h0000_0001);
    rd(IDX_TB1);
    check("tb1", v, 32'h0000_0001);
  endtask
  task automatic t_cmath();
    run(OP_CMPY, 32'h4000_2000, 32'h2000_4000, 32'h0); check("cm", n, 1);
    rd(4'h7); check("res7", v, 32'h0000_2800);
    run(OP_FFT, 32'h0001_0002, 32'h0100_0000, 32'h7FFF_0000); check("fft", n, 5);
    rd(4'h5); check("res5", v, 32'h0100_0002);
    rd(4'h6); check("res6", v, 32'hFF02_0002);
    run(OP_CLD, 32'h0, 32'h0, 32'h0); check("cld", n, 1);
    rd(4'h8); check("res8", v, 32'h1234_5678);
    run(OP_CST, 32'h0, 32'h0, 32'h0); check("cst", n, 1);
    @(negedge clk);
    check("wen", memWrEn, 1);
    check("wdat", memWrData, 32'h1234_5678);
  endtask
  // Every width, ten bytes back to back, then one byte slipped in while busy.
  task automatic t_crc();
    ex = 0;
    for (int w = 0; w < 4; w++)
    begin
      cfg(w << 1);
      @(posedge clk);
      for (int k = 0; k < 10; k++)
      begin
        host.issue(OP_CRC, 32'hA5 ^ k, 32'h04C1_1DB7, 32'h0);
        if (k == 0)
          t0 = cyc;
        ex = crcRef(ex, 8'(8'hA5 ^ k), 8 * (w + 1));
      end
      host.idle();
      check("crc10", cyc - t0, 9);
      rd(IDX_CRC); check("crcw", v, ex);
    end
    @(posedge clk);
    host.issue(OP_FFT, 32'h0, 32'h0, 32'h0);
    t0 = cyc;
    host.issue(OP_CRC, 32'h3C, 32'h04C1_1DB7, 32'h0);
    host.idle();
    check("bg", cyc - t0, 1);
    @(negedge clk);
    check("busy", busy, 1);
    ex = crcRef(ex, 8'h3C, 32);
    run(OP_CMPY, 32'h0, 32'h0, 32'h0);
    rd(IDX_CRC); check("crcbg", v, ex);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the roughly 130 cycles the run needs.
  initial
  begin
    #50000;
    miscompares++;
    wrap_up();
  end
  // Main sequence after three cycles of reset.
  initial
  begin
    resetn = 1'b0;
    rdIdx = 4'h0;
    memRdData = 32'h1234_5678;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_viterbi();
    t_cmath();
    t_crc();
    wrap_up();
  end
endmodule
